//--- rtl/slcd_cfg.svh
// Constants for the serial display controller: offsets, fields, resets and timing.
`ifndef SLCD_CFG_SVH
`define SLCD_CFG_SVH

// System clock rate in hertz.
`define SLCD_CLK_HZ 20000000
// Power-up reset pulse length in milliseconds and in clock cycles.
`define SLCD_PUR_MS 50
`define SLCD_PUR_CYC ((`SLCD_CLK_HZ / 1000) * `SLCD_PUR_MS)
// Backlight drive frequency and half period in clock cycles.
`define SLCD_BL_HZ 600
`define SLCD_BL_HALF (`SLCD_CLK_HZ / (2 * `SLCD_BL_HZ))
// Receiver oversampling and baud divisor, rounded to nearest.
`define SLCD_OVERSAMPLE 16
`define SLCD_BAUD_DIV(b) ((`SLCD_CLK_HZ + (`SLCD_OVERSAMPLE / 2) * (b)) / (`SLCD_OVERSAMPLE * (b)))
// Display enable high time (least, rounded up) and write recovery gap.
`define SLCD_STROBE_NS 500
`define SLCD_STROBE_CYC ((`SLCD_STROBE_NS * (`SLCD_CLK_HZ / 1000000) + 999) / 1000)
`define SLCD_GAP_US 40
`define SLCD_GAP_CYC (`SLCD_GAP_US * (`SLCD_CLK_HZ / 1000000))
// Bit 6 and bit 5 of a function-set command.
`define SLCD_FSET_PATTERN 2'h1
// Word buffer depth.
`define SLCD_FIFO_DEPTH 8

// Register byte offsets.
`define SLCD_REG_CTRL 12'h000
`define SLCD_REG_STATUS 12'h004
`define SLCD_REG_WORD 12'h008
// Control fields and reset value.
`define SLCD_CTRL_BAUD_LSB 0
`define SLCD_CTRL_HOLD_BIT 2
`define SLCD_CTRL_RESET 3'h0
// Status fields.
`define SLCD_ST_TOP_BIT 0
`define SLCD_ST_PUR_BIT 1
`define SLCD_ST_EMPTY_BIT 2
`define SLCD_ST_FULL_BIT 3
`define SLCD_ST_FRAME_BIT 4
`define SLCD_ST_OVR_BIT 5

`endif

//--- rtl/slcd_pkg.sv
// Types shared by the serial display controller.
package slcd_pkg;

	// One received word: top bit selects command or character.
	typedef struct packed {
		logic       select;
		logic [6:0] low;
	} slcd_word_t;

	// Line rate codes held in the control register.
	typedef enum logic [1:0] {
		SLCD_BAUD_300  = 2'h0,
		SLCD_BAUD_1200 = 2'h1,
		SLCD_BAUD_2400 = 2'h2
	} slcd_baud_t;

	// Receiver states, Gray coded along the frame.
	typedef enum logic [1:0] {
		SLCD_RX_IDLE  = 2'h0,
		SLCD_RX_START = 2'h1,
		SLCD_RX_DATA  = 2'h3,
		SLCD_RX_STOP  = 2'h2
	} slcd_rx_state_t;

	// Display writer states, Gray coded along the write cycle.
	typedef enum logic [1:0] {
		SLCD_WR_IDLE   = 2'h0,
		SLCD_WR_SETUP  = 2'h1,
		SLCD_WR_STROBE = 2'h3,
		SLCD_WR_GAP    = 2'h2
	} slcd_wr_state_t;

endpackage

//--- rtl/slcd_fifo.sv
// Word buffer with a registered output stage and valid/ready on both sides.
`timescale 1ns/1ps
module slcd_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// Clock, reset and synchronous flush.
	input  wire logic             i_clock,
	input  wire logic             i_arst_n,
	input  wire logic             i_clear,
	// Filling side.
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	// Draining side.
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic [WIDTH-1:0]      o_data,
	// Levels.
	output logic                  o_full,
	output logic                  o_empty
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             refill;

	// The output register refills whenever storage holds a word and the register is empty or being drained.
	assign push    = i_valid && o_ready;
	assign refill  = (count != '0) && (!o_valid || i_ready);
	assign o_ready = count != (AW + 1)'(DEPTH);
	assign o_full  = !o_ready;
	assign o_empty = !o_valid && (count == '0);

	// Storage has no reset; only slots holding unread words are ever read.
	always_ff @(posedge i_clock) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	// Pointers and occupancy of the storage array.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (i_clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (refill) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			case ({push, refill})
				2'b10: count <= count + 1'b1;
				2'b01: count <= count - 1'b1;
				default: count <= count;
			endcase
		end
	end

	// Registered read data keeps the draining side off the memory path.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_valid <= 1'b0;
			o_data  <= '0;
		end else if (i_clear) begin
			o_valid <= 1'b0;
		end else if (refill) begin
			o_valid <= 1'b1;
			o_data  <= mem[rd_ptr];
		end else if (i_ready) begin
			o_valid <= 1'b0;
		end
	end
endmodule

//--- rtl/slcd_top.sv
// Serial receiver to character display controller with an APB register slave.
//
// Operation
// [R01] Display command/character select comes from the received word's top bit.
// [R02] Select 0 means control command, select 1 means character data.
// [R03] Seven low received bits go straight onto the low display bus lines.
// [R04] Display bus top line comes from a dedicated one-bit register.
// [R05] That register loads the lowest received bit: 1 sets, 0 clears.
// [R06] Loads only on command with bits 7..5 = 001 and bit 1 = 0.
// [R07] All other words leave the top-line register unchanged.
// [R08] Write strobe follows word ready; none during power-up reset or framing error.
// [R09] After power-up a reset pulse of about 50 ms holds the logic.
// [R10] That pulse clears top line, inhibits key display, resets serial and baud.
// [R11] A 600 Hz square wave from the baud generator drives the backlight; the code takes it from its own counter bl_cnt instead.
// [R12] Line rate is 2400, 1200 or 300 baud, 300 by default.
`timescale 1ns/1ps
`include "slcd_cfg.svh"
module slcd_top #(
	parameter int unsigned PUR_CYC      = `SLCD_PUR_CYC,
	parameter int unsigned BAUD_DIV_300 = `SLCD_BAUD_DIV(300),
	parameter int unsigned BL_HALF      = `SLCD_BL_HALF
) (
	// Clock and reset.
	input  wire logic        i_clock,
	input  wire logic        i_arst_n,
	// APB slave.
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic [31:0]      o_prdata,
	// Serial line input.
	input  wire logic        i_serial_rx,
	// Display module.
	output logic [7:0]       o_lcd_data,
	output logic             o_lcd_select,
	output logic             o_lcd_strobe,
	// System signals.
	output logic             o_power_up_reset_pulse,
	output logic             o_key_entry_inhibit,
	output logic             o_backlight_drive
);
	localparam logic [12:0] DIV_300    = 13'(BAUD_DIV_300);
	localparam logic [12:0] DIV_1200   = 13'(`SLCD_BAUD_DIV(1200));
	localparam logic [12:0] DIV_2400   = 13'(`SLCD_BAUD_DIV(2400));
	localparam logic [19:0] PUR_LAST   = 20'(PUR_CYC - 1);
	localparam logic [14:0] BL_LAST    = 15'(BL_HALF - 1);
	localparam logic [9:0]  STB_LAST   = 10'(`SLCD_STROBE_CYC - 1);
	localparam logic [9:0]  GAP_LAST   = 10'(`SLCD_GAP_CYC - 1);
	localparam int unsigned WORD_W     = $bits(slcd_pkg::slcd_word_t);

	// Oversampling divisor for the selected line rate.
	function automatic logic [12:0] baud_div(input logic [1:0] sel);
		case (sel)
			slcd_pkg::SLCD_BAUD_1200: return DIV_1200;
			slcd_pkg::SLCD_BAUD_2400: return DIV_2400;
			default:                  return DIV_300;
		endcase
	endfunction

	// True for a function-set style command that steers the top line.
	function automatic logic is_top_cmd(input slcd_pkg::slcd_word_t w);
		return !w.select && (w.low[6:5] == `SLCD_FSET_PATTERN) && !w.low[1];
	endfunction

	logic                 pur;
	logic [19:0]          pur_cnt;
	logic [2:0]           ctrl;
	logic                 hold;
	logic [12:0]          baud_cnt;
	logic                 tick;
	logic [14:0]          bl_cnt;
	logic                 rx_meta;
	logic                 rx_line;
	slcd_pkg::slcd_rx_state_t rx_state;
	logic [3:0]           tick_cnt;
	logic [2:0]           bit_cnt;
	logic [7:0]           shreg;
	logic                 rx_done;
	logic                 framing_error_flag;
	logic                 pend_valid;
	slcd_pkg::slcd_word_t pend_word;
	logic                 new_word;
	logic                 fifo_in_ready;
	logic                 fifo_valid;
	logic                 fifo_ready;
	logic [WORD_W-1:0]    fifo_data;
	slcd_pkg::slcd_word_t head;
	logic                 fifo_full;
	logic                 fifo_empty;
	slcd_pkg::slcd_wr_state_t wr_state;
	logic [9:0]           wr_cnt;
	slcd_pkg::slcd_word_t cur_word;
	logic                 top_bit;
	logic                 pop;
	logic                 frame_err_sticky;
	logic                 ovr_sticky;
	logic                 ovr_event;
	logic [7:0]           last_word;
	logic                 apb_acc;
	logic                 apb_hit;
	logic                 apb_we;
	logic [31:0]          next_prdata;

	// Power-up reset pulse: starts active and counts out after reset release.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pur     <= 1'b1;
			pur_cnt <= '0;
		end else if (pur) begin
			pur_cnt <= pur_cnt + 1'b1;
			if (pur_cnt == PUR_LAST) begin // [R09]
				pur <= 1'b0;
			end
		end
	end

	// Key entry inhibit and the reset pulse output both follow the same pulse.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_power_up_reset_pulse <= 1'b1;
			o_key_entry_inhibit    <= 1'b1;
		end else begin
			o_power_up_reset_pulse <= pur;
			o_key_entry_inhibit    <= pur; // [R10]
		end
	end

	// Baud generator: one enable pulse per sixteenth of a bit.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			baud_cnt <= '0;
		end else if (pur) begin
			baud_cnt <= '0; // [R10]
		end else if (baud_cnt >= baud_div(ctrl[1:0]) - 1'b1) begin // [R12]
			baud_cnt <= '0;
		end else begin
			baud_cnt <= baud_cnt + 1'b1;
		end
	end
	assign tick = !pur && (baud_cnt == baud_div(ctrl[1:0]) - 1'b1);

	// Backlight square wave; toggled from its own reset-gated half-period counter.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bl_cnt            <= '0;
			o_backlight_drive <= 1'b0;
		end else if (pur) begin
			bl_cnt            <= '0;
			o_backlight_drive <= 1'b0;
		end else if (bl_cnt == BL_LAST) begin
			bl_cnt            <= '0;
			o_backlight_drive <= !o_backlight_drive; // [R11]
		end else begin
			bl_cnt <= bl_cnt + 1'b1;
		end
	end

	// Two-stage synchroniser on the serial pin; the line idles high.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_meta <= 1'b1;
			rx_line <= 1'b1;
		end else begin
			rx_meta <= i_serial_rx;
			rx_line <= rx_meta;
		end
	end

	// Receiver: start checked at mid bit, then eight data bits LSB first.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_state <= slcd_pkg::SLCD_RX_IDLE;
			tick_cnt <= '0;
			bit_cnt  <= '0;
			shreg    <= '0;
			rx_done  <= 1'b0;
			framing_error_flag <= 1'b0;
		end else if (pur) begin
			rx_state <= slcd_pkg::SLCD_RX_IDLE; // [R10]
			tick_cnt <= '0;
			bit_cnt  <= '0;
			rx_done  <= 1'b0;
			framing_error_flag <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (tick) begin
				tick_cnt <= tick_cnt + 1'b1;
				case (rx_state)
					slcd_pkg::SLCD_RX_IDLE: begin
						tick_cnt <= '0;
						if (!rx_line) begin
							rx_state <= slcd_pkg::SLCD_RX_START;
						end
					end
					slcd_pkg::SLCD_RX_START: begin
						if (tick_cnt == 4'h7) begin
							tick_cnt <= '0;
							bit_cnt  <= '0;
							rx_state <= rx_line ? slcd_pkg::SLCD_RX_IDLE
							                    : slcd_pkg::SLCD_RX_DATA;
						end
					end
					slcd_pkg::SLCD_RX_DATA: begin
						if (tick_cnt == 4'hF) begin
							shreg   <= {rx_line, shreg[7:1]};
							bit_cnt <= bit_cnt + 1'b1;
							if (bit_cnt == 3'h7) begin
								rx_state <= slcd_pkg::SLCD_RX_STOP;
							end
						end
					end
					slcd_pkg::SLCD_RX_STOP: begin
						if (tick_cnt == 4'hF) begin
							rx_done  <= 1'b1;
							framing_error_flag <= !rx_line;
							rx_state <= slcd_pkg::SLCD_RX_IDLE;
						end
					end
					default: rx_state <= slcd_pkg::SLCD_RX_IDLE;
				endcase
			end
		end
	end

	// A word with a bad stop bit never reaches the buffer, so never the display.
	assign new_word  = rx_done && !framing_error_flag; // [R08]
	assign ovr_event = new_word && pend_valid && !fifo_in_ready;

	// One-word holding stage: the serial line cannot be stalled, so a full
	// buffer stalls this stage and a further word is counted as overrun.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pend_valid <= 1'b0;
			pend_word  <= '0;
		end else if (pur) begin
			pend_valid <= 1'b0;
		end else if (new_word && (!pend_valid || fifo_in_ready)) begin
			pend_valid <= 1'b1;
			pend_word  <= shreg;
		end else if (fifo_in_ready) begin
			pend_valid <= 1'b0;
		end
	end

	// Nine-word buffer (eight stored plus the output register) between receiver and display writer.
	slcd_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (`SLCD_FIFO_DEPTH)
	) u_fifo (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_clear  (pur),
		.i_valid  (pend_valid),
		.o_ready  (fifo_in_ready),
		.i_data   (pend_word),
		.o_valid  (fifo_valid),
		.i_ready  (fifo_ready),
		.o_data   (fifo_data),
		.o_full   (fifo_full),
		.o_empty  (fifo_empty)
	);
	assign head = fifo_data;

	// Software hold stalls draining; power-up reset keeps the strobe off.
	assign fifo_ready = (wr_state == slcd_pkg::SLCD_WR_IDLE) && !hold && !pur; // [R08]
	assign pop        = fifo_valid && fifo_ready;

	// Display writer: setup cycle, enable pulse, then write recovery gap.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_state     <= slcd_pkg::SLCD_WR_IDLE;
			wr_cnt       <= '0;
			cur_word     <= '0;
			o_lcd_select <= 1'b0;
			o_lcd_strobe <= 1'b0;
		end else if (pur) begin
			wr_state     <= slcd_pkg::SLCD_WR_IDLE;
			o_lcd_strobe <= 1'b0; // [R08]
		end else begin
			case (wr_state)
				slcd_pkg::SLCD_WR_IDLE: begin
					if (pop) begin
						cur_word     <= head; // [R03]
						o_lcd_select <= head.select; // [R01] [R02]
						wr_state     <= slcd_pkg::SLCD_WR_SETUP;
					end
				end
				slcd_pkg::SLCD_WR_SETUP: begin
					o_lcd_strobe <= 1'b1; // [R08]
					wr_cnt       <= '0;
					wr_state     <= slcd_pkg::SLCD_WR_STROBE;
				end
				slcd_pkg::SLCD_WR_STROBE: begin
					wr_cnt <= wr_cnt + 1'b1;
					if (wr_cnt == STB_LAST) begin
						o_lcd_strobe <= 1'b0;
						wr_cnt       <= '0;
						wr_state     <= slcd_pkg::SLCD_WR_GAP;
					end
				end
				slcd_pkg::SLCD_WR_GAP: begin
					wr_cnt <= wr_cnt + 1'b1;
					if (wr_cnt == GAP_LAST) begin
						wr_state <= slcd_pkg::SLCD_WR_IDLE;
					end
				end
				default: wr_state <= slcd_pkg::SLCD_WR_IDLE;
			endcase
		end
	end

	// Top line register, clocked at the falling enable of a qualifying command.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			top_bit <= 1'b0;
		end else if (pur) begin
			top_bit <= 1'b0; // [R10]
		end else if (wr_state == slcd_pkg::SLCD_WR_STROBE && wr_cnt == STB_LAST
		             && is_top_cmd(cur_word)) begin // [R06] [R07]
			top_bit <= cur_word.low[0]; // [R05]
		end
	end
	assign o_lcd_data = {top_bit, cur_word.low}; // [R04] [R03]

	// Sticky error flags; a new event wins over a clear in the same cycle.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			frame_err_sticky <= 1'b0;
			ovr_sticky <= 1'b0;
			last_word  <= '0;
		end else begin
			if (rx_done) begin
				last_word <= shreg;
			end
			if (rx_done && framing_error_flag) begin
				frame_err_sticky <= 1'b1;
			end else if (apb_we && i_paddr == `SLCD_REG_STATUS
			             && i_pwdata[`SLCD_ST_FRAME_BIT]) begin
				frame_err_sticky <= 1'b0;
			end
			if (ovr_event) begin
				ovr_sticky <= 1'b1;
			end else if (apb_we && i_paddr == `SLCD_REG_STATUS
			             && i_pwdata[`SLCD_ST_OVR_BIT]) begin
				ovr_sticky <= 1'b0;
			end
		end
	end

	// APB decode; the answer comes one cycle into the access phase.
	assign apb_acc = i_psel && i_penable;
	assign apb_hit = (i_paddr == `SLCD_REG_CTRL) || (i_paddr == `SLCD_REG_STATUS)
	                 || (i_paddr == `SLCD_REG_WORD);
	assign apb_we  = apb_acc && o_pready && i_pwrite;
	assign hold    = ctrl[`SLCD_CTRL_HOLD_BIT];

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		next_prdata = '0;
		case (i_paddr)
			`SLCD_REG_CTRL:   next_prdata[2:0] = ctrl;
			`SLCD_REG_STATUS: begin
				next_prdata[`SLCD_ST_TOP_BIT]   = top_bit;
				next_prdata[`SLCD_ST_PUR_BIT]   = pur;
				next_prdata[`SLCD_ST_EMPTY_BIT] = fifo_empty && !pend_valid;
				next_prdata[`SLCD_ST_FULL_BIT]  = fifo_full;
				next_prdata[`SLCD_ST_FRAME_BIT] = frame_err_sticky;
				next_prdata[`SLCD_ST_OVR_BIT]   = ovr_sticky;
			end
			`SLCD_REG_WORD:   next_prdata[7:0] = last_word;
			default:          next_prdata = '0;
		endcase
	end

	// Answer registers: pready is a one-cycle pulse per transfer.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= '0;
		end else if (apb_acc && !o_pready) begin
			o_pready  <= 1'b1;
			o_pslverr <= !apb_hit;
			o_prdata  <= i_pwrite ? 32'h0000_0000 : next_prdata;
		end else begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end
	end

	// Control register: line rate code and drain hold.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl <= `SLCD_CTRL_RESET; // [R12]
		end else if (apb_we && i_paddr == `SLCD_REG_CTRL) begin
			ctrl <= i_pwdata[2:0];
		end
	end

	// Checks on the display path and timing chain.
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	sequence s_pop_taken;
		pop && !pur;
	endsequence

	sequence s_strobe_begins;
		!o_lcd_strobe ##1 o_lcd_strobe;
	endsequence

	a_select_from_msb: assert property ( // [R01] [R02]
		s_pop_taken |=> o_lcd_select == $past(head.select))
		else $error("display select does not follow the word top bit");
	a_low_bits_pass: assert property ( // [R03]
		s_pop_taken |-> ##1 s_strobe_begins ##0 o_lcd_data[6:0] == $past(head.low, 2))
		else $error("low display lines differ from the received word");
	a_top_bit_load: assert property ( // [R04] [R05] [R06]
		$fell(o_lcd_strobe) && !pur && is_top_cmd(cur_word)
		|-> top_bit == cur_word.low[0])
		else $error("top line register missed a qualifying command");
	a_top_bit_hold: assert property ( // [R07]
		!pur && !($fell(o_lcd_strobe) && is_top_cmd(cur_word)) |-> $stable(top_bit))
		else $error("top line register changed without a qualifying command");
	a_strobe_no_reset: assert property ( // [R08]
		o_lcd_strobe |-> !pur && $past(!pur))
		else $error("display strobe during power-up reset");
	a_bad_stop_dropped: assert property ( // [R08]
		rx_done && framing_error_flag && !pend_valid |=> !pend_valid)
		else $error("word with framing error entered the buffer");
	a_pur_length: assert property ( // [R09]
		$fell(pur) |-> $past(pur_cnt) == PUR_LAST)
		else $error("power-up reset pulse has the wrong length");
	a_pur_clears: assert property ( // [R10]
		pur |=> !top_bit && baud_cnt == '0 && rx_state == slcd_pkg::SLCD_RX_IDLE)
		else $error("power-up reset left state uncleared");
	a_backlight_half: assert property ( // [R11]
		$changed(o_backlight_drive) && !pur && $past(!pur) |-> $past(bl_cnt) == BL_LAST)
		else $error("backlight half period wrong");
	a_baud_period: assert property ( // [R12]
		tick |=> baud_cnt == 13'h0000)
		else $error("baud tick not at the divisor end");
endmodule

//--- bench/slcd_tx_model.sv
// Serial line model that sends 8N1 frames, LSB first, into the receiver.
`timescale 1ns/1ps
module slcd_tx_model #(
	parameter int unsigned BIT_CYC = 64
) (
	// Clock.
	input  wire logic i_clock,
	// Serial line, idle high.
	output logic      o_line
);
	// The line rests high between frames, as a real sender leaves it.
	initial begin
		o_line = 1'b1;
	end

	// Sends one frame; a low stop bit creates a framing fault on purpose.
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge i_clock);
			o_line <= f[i];
			repeat (BIT_CYC - 1) @(posedge i_clock);
		end
		@(posedge i_clock);
		o_line <= 1'b1;
	endtask
endmodule

//--- bench/serial_lcd_msb_control_tb.sv
// Bench for the serial display controller: APB, serial frames, display outputs.
`timescale 1ns/1ps
`include "slcd_cfg.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch %s expected %0h seen %0h", n, e, g); end end
module serial_lcd_msb_control_tb;
	localparam int unsigned PUR  = 100;
	localparam int unsigned BDIV = 4;
	localparam int unsigned BLH  = 20;
	// Design-facing signals.
	logic        clk;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic        rx;
	logic [7:0]  lcd;
	logic        sel;
	logic        strobe;
	logic        pur;
	logic        inhibit;
	logic        bl;
	// Bench state.
	int          err_count;
	int          samples_checked;
	int          strobes;
	int          s;
	int          n;
	logic [7:0]  cap;
	logic        cap_sel;
	logic [31:0] rd;
	logic        se;
	logic        b;

	slcd_top #(.PUR_CYC(PUR), .BAUD_DIV_300(BDIV), .BL_HALF(BLH)) dut (
		.i_clock(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_prdata(prdata), .i_serial_rx(rx), .o_lcd_data(lcd),
		.o_lcd_select(sel), .o_lcd_strobe(strobe), .o_power_up_reset_pulse(pur),
		.o_key_entry_inhibit(inhibit), .o_backlight_drive(bl));

	slcd_tx_model #(.BIT_CYC(16 * BDIV)) tx (.i_clock(clk), .o_line(rx));

	// The clock runs at 20 MHz.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Each rising strobe is one display write; bus and select are captured then.
	always @(posedge strobe) begin
		strobes++;
		cap = lcd;
		cap_sel = sel;
	end

	// One APB transfer; the request stands until pready is sampled high at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		se = pslverr;
		`CHK("apb answer", 1'b1, pready)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits, bounded, for one more write strobe to rise and fall again.
	task automatic wait_strobe(input int c);
		int k;
		k = 0;
		while ((strobes == c || strobe !== 1'b0) && k < 2000) begin
			@(negedge clk);
			k++;
		end
		`CHK("strobe count", c + 1, strobes)
	endtask

	// Sends a good frame and checks what the display was given.
	task automatic show(input logic [7:0] w, input logic top);
		int c;
		c = strobes;
		tx.send(w, 1'b1);
		wait_strobe(c);
		`CHK("select", w[7], cap_sel)
		`CHK("low bus", w[6:0], cap[6:0])
		`CHK("top line", top, lcd[7])
	endtask

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// A hang anywhere ends the run as a failure.
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end

	initial begin
		err_count = 0;
		samples_checked = 0;
		strobes = 0;
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		`CHK("reset pulse", 1'b1, pur)
		`CHK("key inhibit", 1'b1, inhibit)
		`CHK("top reset", 1'b0, lcd[7])
		apb(1'b0, `SLCD_REG_STATUS, 32'h0);
		`CHK("status pulse", 1'b1, rd[1])
		apb(1'b0, `SLCD_REG_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h0, rd)
		repeat (PUR - 20) @(negedge clk);
		`CHK("pulse held", 1'b1, pur)
		repeat (30) @(negedge clk);
		`CHK("pulse end", 1'b0, pur)
		`CHK("inhibit end", 1'b0, inhibit)
		$display("test reset done");
		show(8'hC1, 1'b0);
		show(8'h21, 1'b1);
		show(8'h23, 1'b1);
		show(8'hA0, 1'b1);
		show(8'h40, 1'b1);
		show(8'h61, 1'b1);
		show(8'h3C, 1'b0);
		$display("test top line done");
		s = strobes;
		tx.send(8'h21, 1'b0);
		repeat (300) @(negedge clk);
		`CHK("bad stop strobe", s, strobes)
		`CHK("bad stop top", 1'b0, lcd[7])
		apb(1'b0, `SLCD_REG_STATUS, 32'h0);
		`CHK("frame err flag", 1'b1, rd[4])
		apb(1'b1, `SLCD_REG_STATUS, 32'h10);
		apb(1'b0, `SLCD_REG_STATUS, 32'h0);
		`CHK("frame err cleared", 1'b0, rd[4])
		apb(1'b0, `SLCD_REG_WORD, 32'h0);
		`CHK("last word", 8'h21, rd[7:0])
		apb(1'b0, 12'h00C, 32'h0);
		`CHK("unmapped err", 1'b1, se)
		`CHK("unmapped data", 32'h0, rd)
		apb(1'b1, `SLCD_REG_CTRL, 32'h2);
		apb(1'b0, `SLCD_REG_CTRL, 32'h0);
		`CHK("rate code", 32'h2, rd)
		$display("test registers done");
		apb(1'b1, `SLCD_REG_CTRL, 32'h4);
		for (int i = 0; i < 10; i++) tx.send(8'(8'hC0 + i), 1'b1);
		repeat (100) @(negedge clk);
		apb(1'b0, `SLCD_REG_STATUS, 32'h0);
		`CHK("full", 1'b1, rd[3])
		`CHK("no overrun", 1'b0, rd[5])
		apb(1'b1, `SLCD_REG_CTRL, 32'h0);
		for (int i = 0; i < 10; i++) begin
			wait_strobe(strobes);
			`CHK("drain order", 7'h40 + i, cap[6:0])
		end
		apb(1'b0, `SLCD_REG_STATUS, 32'h0);
		`CHK("empty", 1'b1, rd[2])
		$display("test buffer done");
		n = 0;
		b = bl;
		while (bl === b && n < 100) begin
			@(negedge clk);
			n++;
		end
		b = bl;
		n = 0;
		while (bl === b && n < 100) begin
			@(negedge clk);
			n++;
		end
		`CHK("backlight half", int'(BLH), n)
		$display("test backlight done");
		tally_and_finish();
	end
endmodule
